/* File: rtl/audio_pb_pkg.sv */
// constants shared by the audio playback control register block
package audio_pb_pkg;

  // clock and engine sizing
  localparam int CLK_HZ     = 25_000_000;
  localparam int ADDR_W     = 22;
  localparam int GADDR_W    = 20;
  localparam int VOL_W      = 8;
  localparam int RATE_W     = 16;
  localparam int FMT_W      = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int ACC_W      = 26;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_PLAYBACK_VOLUME = 22'h10247C;
  localparam logic [ADDR_W-1:0] OFS_SYNTH_VOLUME    = 22'h102480;
  localparam logic [ADDR_W-1:0] OFS_PB_START        = 22'h1024A4;
  localparam logic [ADDR_W-1:0] OFS_PB_LENGTH       = 22'h1024A8;
  localparam logic [ADDR_W-1:0] OFS_PB_READ_POINTER = 22'h1024AC;
  localparam logic [ADDR_W-1:0] OFS_PB_SAMPLE_RATE  = 22'h1024B0;
  localparam logic [ADDR_W-1:0] OFS_PB_FORMAT       = 22'h1024B4;
  localparam logic [ADDR_W-1:0] OFS_PB_LOOP         = 22'h1024B8;
  localparam logic [ADDR_W-1:0] OFS_PB_TRIGGER      = 22'h1024BC;

  // reset values
  localparam logic [VOL_W-1:0]   RST_VOLUME = 8'hFF;
  localparam logic [RATE_W-1:0]  RST_RATE   = 16'h1F40;
  localparam logic [FMT_W-1:0]   RST_FORMAT = 2'h0;
  localparam logic [GADDR_W-1:0] RST_GADDR  = 20'h00000;

  // field positions
  localparam int LOOP_BIT = 0;
  localparam int TRIG_BIT = 0;

  // sample formats
  localparam logic [FMT_W-1:0] FMT_LINEAR = 2'h0;
  localparam logic [FMT_W-1:0] FMT_ULAW   = 2'h1;
  localparam logic [FMT_W-1:0] FMT_ADPCM  = 2'h2;

  typedef enum logic [0:0] {ST_IDLE, ST_PLAY} pb_state_t;

endpackage

/* File: rtl/audio_playback_control_regs.sv */
// audio playback control registers, fetch engine, sample pacing and volume scaling
//
// Functional notes
// - synthesizer samples are scaled by an 8-bit volume that resets to 0xFF (loudest), 0 mutes.
// - playback samples are scaled by their own 8-bit volume, reset 0xFF, 0 mutes.
// - any write to the trigger bit starts playback whatever value is written.
// - the trigger bit reads 1 while playback runs and 0 once it has finished.
// - with looping on, after the last byte the engine restarts from the start address.
// - the loop bit enables looping at 1, disables it at 0, and resets to 0.
// - a 2-bit format selects linear (00), mu-law (01) or 4-bit ADPCM (10); 11 is undefined.
// - a 16-bit rate in hertz paces how fast the engine consumes samples.
// - fetching starts at a 20-bit start address in graphics memory set by software.
// - a 20-bit length gives the number of bytes played from the start address.
// - a read-only 20-bit pointer holds the address currently being played.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo with flush
module pb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  // power of two keeps the pointer wrap free
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("pb_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr_r;
  logic [PW:0]      rd_ptr_r;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {PW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[PW-1:0]];

  // storage
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[wr_ptr_r[PW-1:0]] <= in_data;
  end

  // pointers; flush discards everything held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (out_valid && out_ready)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // pb_fifo

////////////////////////////////////////////////////////////////////////////////
// top: wishbone slave, playback engine, volume stages
module audio_playback_control_regs
  import audio_pb_pkg::*;
#(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  // wishbone classic slave
  input  wire logic               wb_cyc,
  input  wire logic               wb_stb,
  input  wire logic               wb_we,
  input  wire logic [ADDR_W-1:0]  wb_adr,
  input  wire logic [3:0]         wb_sel,
  input  wire logic [31:0]        wb_dat_w,
  output logic      [31:0]        wb_dat_r,
  output logic                    wb_ack,
  // graphics memory byte read port
  output logic                    mem_req,
  output logic      [GADDR_W-1:0] mem_addr,
  input  wire logic               mem_ack,
  input  wire logic [7:0]         mem_rdata,
  // synthesizer path
  input  wire logic               synth_valid,
  input  wire logic [7:0]         synth_sample,
  output logic                    synth_out_valid,
  output logic      [15:0]        synth_out,
  // playback path towards the decoder
  output logic                    pb_strobe,
  output logic      [FMT_W-1:0]   pb_format,
  output logic      [7:0]         pb_code,
  output logic      [15:0]        pb_scaled,
  output logic      [VOL_W-1:0]   pb_gain,
  output logic                    pb_busy
);

  if (FIFO_W != 8) begin : g_bad_width
    $error("audio_playback_control_regs: FIFO_W must be 8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register storage and bus slave
  logic [VOL_W-1:0]   pb_vol_r;
  logic [VOL_W-1:0]   synth_vol_r;
  logic [GADDR_W-1:0] start_r;
  logic [GADDR_W-1:0] length_r;
  logic [GADDR_W-1:0] read_ptr_r;
  logic [RATE_W-1:0]  rate_r;
  logic [FMT_W-1:0]   format_r;
  logic               loop_r;
  logic               busy_r;
  logic [31:0]        rd_nxt;
  logic [31:0]        lane_mask;
  logic [31:0]        wr_word;
  logic               req;
  logic               wr;
  logic               trigger;

  // one-cycle answer: a request is taken on the edge where ack is still low
  assign req     = wb_cyc && wb_stb && !wb_ack;
  assign wr      = req && wb_we;
  assign trigger = wr && (wb_adr == OFS_PB_TRIGGER) && wb_sel[0];

  // merge written byte lanes into the addressed register's current value;
  // the read mux already selects that value, so no second mux is needed
  assign lane_mask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  assign wr_word   = (rd_nxt & ~lane_mask) | (wb_dat_w & lane_mask);

  // read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (wb_adr)
      OFS_PLAYBACK_VOLUME: rd_nxt[VOL_W-1:0]    = pb_vol_r;
      OFS_SYNTH_VOLUME:    rd_nxt[VOL_W-1:0]    = synth_vol_r;
      OFS_PB_START:        rd_nxt[GADDR_W-1:0]  = start_r;
      OFS_PB_LENGTH:       rd_nxt[GADDR_W-1:0]  = length_r;
      OFS_PB_READ_POINTER: rd_nxt[GADDR_W-1:0]  = read_ptr_r;
      OFS_PB_SAMPLE_RATE:  rd_nxt[RATE_W-1:0]   = rate_r;
      OFS_PB_FORMAT:       rd_nxt[FMT_W-1:0]    = format_r;
      OFS_PB_LOOP:         rd_nxt[LOOP_BIT]     = loop_r;
      OFS_PB_TRIGGER:      rd_nxt[TRIG_BIT]     = busy_r;
      default:             rd_nxt               = 32'h00000000;
    endcase
  end

  // ack and read data; ack drops the cycle after it is given
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end
    else
    begin
      wb_ack <= req;
      if (req && !wb_we)
        wb_dat_r <= rd_nxt;
    end
  end

  // software-written fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pb_vol_r    <= RST_VOLUME;
      synth_vol_r <= RST_VOLUME;
      start_r     <= RST_GADDR;
      length_r    <= RST_GADDR;
      rate_r      <= RST_RATE;
      format_r    <= RST_FORMAT;
      loop_r      <= 1'b0;
    end
    else if (wr)
    begin
      case (wb_adr)
        OFS_PLAYBACK_VOLUME: pb_vol_r    <= wr_word[VOL_W-1:0];
        OFS_SYNTH_VOLUME:    synth_vol_r <= wr_word[VOL_W-1:0];
        OFS_PB_START:        start_r     <= wr_word[GADDR_W-1:0];
        OFS_PB_LENGTH:       length_r    <= wr_word[GADDR_W-1:0];
        OFS_PB_SAMPLE_RATE:  rate_r      <= wr_word[RATE_W-1:0];
        OFS_PB_FORMAT:       format_r    <= wr_word[FMT_W-1:0];
        OFS_PB_LOOP:         loop_r      <= wr_word[LOOP_BIT];
        default:             ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // playback engine: fetcher fills the fifo, paced consumer drains it
  pb_state_t          state_r;
  logic [GADDR_W-1:0] fetch_r;
  logic [GADDR_W-1:0] end_addr;
  logic               discard_r;
  logic [ACC_W-1:0]   acc_r;
  logic [ACC_W-1:0]   acc_sum;
  logic               tick;
  logic               nib_hi_r;
  logic               f_in_ready;
  logic               f_out_valid;
  logic [7:0]         f_out_data;
  logic               consume;
  logic               pop;
  logic               fetch_done;
  logic [GADDR_W-1:0] ptr_next;

  // end address wraps inside the 20-bit graphics space
  assign end_addr   = start_r + length_r;
  assign fetch_done = (fetch_r == end_addr);
  assign ptr_next   = read_ptr_r + 1'b1;

  // one consumption per sample period; adpcm takes two nibbles per byte
  // no consumption in the cycle the pointer sits at the end, so pointer and fifo stay paired
  assign consume = (state_r == ST_PLAY) && tick && f_out_valid && (read_ptr_r != end_addr);
  assign pop     = consume && ((format_r != FMT_ADPCM) || nib_hi_r);

  pb_fifo #(
    .WIDTH     (FIFO_W),
    .DEPTH     (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (trigger),
    .in_data   (mem_rdata),
    .in_valid  (mem_req && mem_ack && !discard_r),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (pop)
  );

  // sample-rate pacing: phase accumulator against the system clock
  assign acc_sum = acc_r + ACC_W'(rate_r);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= '0;
      tick  <= 1'b0;
    end
    else if (trigger || state_r != ST_PLAY)
    begin
      acc_r <= '0;
      tick  <= 1'b0;
    end
    else if (acc_sum >= ACC_W'(CLK_HZ))
    begin
      acc_r <= acc_sum - ACC_W'(CLK_HZ);
      tick  <= 1'b1;
    end
    else
    begin
      acc_r <= acc_sum;
      tick  <= 1'b0;
    end
  end

  // fetcher: one byte outstanding, requested only when the fifo has room
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req   <= 1'b0;
      fetch_r   <= RST_GADDR;
      discard_r <= 1'b0;
    end
    else if (trigger)
    begin
      // a byte still in flight belongs to the old run; its address must stand until the ack
      discard_r <= mem_req && !mem_ack;
      mem_req   <= mem_req && !mem_ack;
      if (!mem_req || mem_ack)
        fetch_r <= start_r;
    end
    else if (mem_req)
    begin
      if (mem_ack)
      begin
        mem_req   <= 1'b0;
        discard_r <= 1'b0;
        // limitation: start is taken again here, so do not rewrite it right after a trigger
        if (discard_r)
          fetch_r <= start_r;
        else
          fetch_r <= fetch_r + 1'b1;
      end
    end
    else if (state_r == ST_PLAY)
    begin
      if (fetch_done && loop_r)
        fetch_r <= start_r;
      else if (!fetch_done && f_in_ready)
        mem_req <= 1'b1;
    end
  end

  assign mem_addr = fetch_r;

  // consumer: pointer, busy flag and end of playback
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= ST_IDLE;
      read_ptr_r <= RST_GADDR;
      nib_hi_r   <= 1'b0;
    end
    else if (trigger)
    begin
      state_r    <= ST_PLAY;
      read_ptr_r <= start_r;
      nib_hi_r   <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE: ;
        ST_PLAY:
        begin
          if (read_ptr_r == end_addr)
          begin
            if (loop_r)
              read_ptr_r <= start_r;
            else
              state_r <= ST_IDLE;
          end
          else if (consume)
          begin
            nib_hi_r <= (format_r == FMT_ADPCM) && !nib_hi_r;
            if (pop)
              read_ptr_r <= ptr_next;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign busy_r  = (state_r == ST_PLAY);
  assign pb_busy = busy_r;

  //////////////////////////////////////////////////////////////////////////////
  // playback output stage: code, format and gain go to the decoder
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pb_strobe <= 1'b0;
      pb_format <= RST_FORMAT;
      pb_code   <= 8'h00;
      pb_scaled <= 16'h0000;
      pb_gain   <= RST_VOLUME;
    end
    else
    begin
      pb_strobe <= consume;
      pb_gain   <= pb_vol_r;
      if (consume)
      begin
        pb_format <= format_r;
        if (format_r == FMT_ADPCM)
          pb_code <= {4'h0, nib_hi_r ? f_out_data[7:4] : f_out_data[3:0]};
        else
          pb_code <= f_out_data;
        // linear bytes (and the undefined code, treated as linear) are scaled here;
        // companded codes are scaled after decoding
        if (format_r != FMT_ULAW && format_r != FMT_ADPCM)
          pb_scaled <= 16'($signed(f_out_data) * $signed({1'b0, pb_vol_r}));
        else
          pb_scaled <= 16'h0000;
      end
    end
  end

  // synthesizer volume stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synth_out_valid <= 1'b0;
      synth_out       <= 16'h0000;
    end
    else
    begin
      synth_out_valid <= synth_valid;
      if (synth_valid)
        synth_out <= 16'($signed(synth_sample) * $signed({1'b0, synth_vol_r}));
    end
  end

endmodule // audio_playback_control_regs

/* File: dv/audio_pb_checker_asserts.sv */
// concurrent checks on the ports of the audio playback register block
`timescale 1ns/1ps

module audio_pb_checker
  import audio_pb_pkg::*;
(
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               wb_cyc,
  input wire logic               wb_stb,
  input wire logic               wb_we,
  input wire logic               wb_ack,
  input wire logic [31:0]        wb_dat_r,
  input wire logic               mem_req,
  input wire logic [GADDR_W-1:0] mem_addr,
  input wire logic               mem_ack,
  input wire logic               synth_valid,
  input wire logic [7:0]         synth_sample,
  input wire logic               synth_out_valid,
  input wire logic [15:0]        synth_out,
  input wire logic               pb_strobe,
  input wire logic [FMT_W-1:0]   pb_format,
  input wire logic [7:0]         pb_code,
  input wire logic [15:0]        pb_scaled,
  input wire logic [VOL_W-1:0]   pb_gain
);

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: a taken request is answered by exactly one ack cycle
  sequence bus_req_s;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence ack_once_s;
    wb_ack ##1 !wb_ack;
  endsequence

  bus_ack_once_a: assert property (bus_req_s |=> ack_once_s)
    else $error("bus request not answered by a single ack");
  rdata_hold_a: assert property (!(wb_cyc && wb_stb && !wb_we && !wb_ack) |=> $stable(wb_dat_r))
    else $error("read data moved without a read");

  ////////////////////////////////////////////////////////////////////////////////
  // volume stages; a zero synth sample must give silence, playback scaling is code times gain
  synth_lat_a: assert property (synth_valid |=> synth_out_valid)
    else $error("synth output late");
  synth_mute_a: assert property (synth_valid && synth_sample == 8'h00 |=> synth_out == 16'h0000)
    else $error("silent synth sample not silent");
  pb_scale_a: assert property (pb_strobe && pb_format != FMT_ULAW && pb_format != FMT_ADPCM
    |-> pb_scaled == $signed({{8{pb_code[7]}}, pb_code}) * $signed({8'h00, pb_gain}))
    else $error("playback scaling wrong");
  pb_zero_a: assert property (pb_strobe && (pb_format == FMT_ULAW || pb_format == FMT_ADPCM)
    |-> pb_scaled == 16'h0000)
    else $error("scaled output not zero for coded format");
  strobe_pulse_a: assert property (pb_strobe |=> !pb_strobe)
    else $error("sample strobe longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////////
  // memory fetch handshake
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped or moved before ack");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("fetch request held after ack");

endmodule // audio_pb_checker

bind audio_playback_control_regs audio_pb_checker audio_pb_checker_inst (.clk, .resetn, .wb_cyc,
  .wb_stb, .wb_we, .wb_ack, .wb_dat_r, .mem_req, .mem_addr, .mem_ack, .synth_valid, .synth_sample,
  .synth_out_valid, .synth_out, .pb_strobe, .pb_format, .pb_code, .pb_scaled, .pb_gain);

/* File: dv/audio_playback_control_regs_tb.sv */
// self-checking bench for the audio playback register block
`timescale 1ns/1ps

module audio_playback_control_regs_tb
  import audio_pb_pkg::*;
;
  logic               clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, mem_req, mem_ack;
  logic               synth_valid, synth_out_valid, pb_strobe, pb_busy;
  logic [ADDR_W-1:0]  wb_adr;
  logic [3:0]         wb_sel;
  logic [31:0]        wb_dat_w, wb_dat_r, rd;
  logic [GADDR_W-1:0] mem_addr;
  logic [7:0]         mem_rdata, synth_sample, pb_code, pb_gain;
  logic [15:0]        synth_out, pb_scaled;
  logic [FMT_W-1:0]   pb_format;
  int                 failures, cmp_count, n;

  audio_playback_control_regs audio_playback_control_regs_inst (.clk, .resetn, .wb_cyc, .wb_stb,
    .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .synth_valid, .synth_sample, .synth_out_valid, .synth_out, .pb_strobe,
    .pb_format, .pb_code, .pb_scaled, .pb_gain, .pb_busy);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // memory answers one cycle after a request; data wanders otherwise so stale bytes show
  always @(posedge clk)
  begin
    mem_ack   <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack) ? (mem_addr[7:0] ^ 8'h5A) : ~mem_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; ack and read data are taken at the same edge
  task wb(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat_w <= d; wb_sel <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    rd = wb_dat_r;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    if (k >= 50)
    begin
      chk(wb_ack, 1);
      conclude;
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // watch strobes until busy ends or nmax samples seen; bytes follow start address,
  // adpcm gives two codes per byte, low nibble first; playback gain is 0x80 by then
  task watch(input logic [GADDR_W-1:0] st, input int len, input int nmax, input logic [1:0] fmt);
    int          c, last;
    logic [7:0]  b;
    logic [15:0] e16;
    n = 0;
    for (c = 0; c < 20000 && pb_busy === 1'b1 && n < nmax; c++)
    begin
      @(posedge clk);
      if (pb_strobe === 1'b1)
      begin
        b = 8'(((st + ((fmt == FMT_ADPCM) ? n / 2 : n) % len) & 8'hFF) ^ 8'h5A);
        if (fmt == FMT_ADPCM)
          chk(pb_code, n[0] ? {4'h0, b[7:4]} : {4'h0, b[3:0]});
        else
          chk(pb_code, b);
        chk(pb_format, fmt);
        e16 = (fmt == FMT_LINEAR) ? 16'($signed(b) * 16'sh0080) : 16'h0000;
        chk(pb_scaled, e16);
        if (n == 1)
          chk((c - last) inside {381, 382}, 1);
        last = c;
        n++;
      end
    end
    if (c >= 20000)
    begin
      chk(c, 0);
      conclude;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rc(OFS_SYNTH_VOLUME, 32'hFF);
    rc(OFS_PLAYBACK_VOLUME, 32'hFF);
    rc(OFS_PB_TRIGGER, 32'h0);
    rc(OFS_PB_LOOP, 32'h0);
    rc(OFS_PB_FORMAT, 32'h0);
    rc(OFS_PB_SAMPLE_RATE, 32'h1F40);
    rc(OFS_PB_READ_POINTER, 32'h0);
    rc(22'h102490, 32'h0);
  endtask

  task t_synth(input logic [7:0] v, input logic [7:0] s, input logic [15:0] exp);
    wr(OFS_SYNTH_VOLUME, {24'h0, v});
    rc(OFS_SYNTH_VOLUME, {24'h0, v});
    @(posedge clk);
    synth_valid <= 1'b1; synth_sample <= s;
    @(posedge clk);
    synth_valid <= 1'b0;
    @(posedge clk);
    chk(synth_out_valid, 1);
    chk(synth_out, exp);
  endtask

  // starts playback of len bytes from st at rate 0xFFFF; checks format readback and that the trigger bit reads 1
  task t_play(input logic [GADDR_W-1:0] st, input int len, input logic [1:0] fmt);
    wr(OFS_PB_START, st);
    wr(OFS_PB_LENGTH, len);
    wr(OFS_PB_SAMPLE_RATE, 32'hFFFF);
    wr(OFS_PB_FORMAT, fmt);
    rc(OFS_PB_FORMAT, fmt);
    wr(OFS_PB_TRIGGER, 32'h0);
    rc(OFS_PB_TRIGGER, 32'h1);
  endtask

  initial
  begin
    resetn = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = '0; wb_sel = 4'h0;
    wb_dat_w = '0; mem_ack = 1'b0; mem_rdata = 8'h00; synth_valid = 1'b0; synth_sample = 8'h00;
    failures = 0; cmp_count = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_synth(8'h40, 8'hFD, 16'hFF40);
    t_synth(8'hFF, 8'h7F, 16'h7E81);
    t_synth(8'h00, 8'h80, 16'h0000);
    wr(OFS_PLAYBACK_VOLUME, 32'h80);
    rc(OFS_PLAYBACK_VOLUME, 32'h80);
    chk(pb_gain, 8'h80);
    t_play(20'h00100, 3, FMT_LINEAR);
    watch(20'h00100, 3, 99, FMT_LINEAR);
    chk(n, 3);
    rc(OFS_PB_TRIGGER, 32'h0);
    wr(OFS_PB_READ_POINTER, 32'h12345);
    rc(OFS_PB_READ_POINTER, 32'h00103);
    wr(OFS_PB_LOOP, 32'h1);
    rc(OFS_PB_LOOP, 32'h1);
    t_play(20'hFFFF2, 2, FMT_ULAW);
    watch(20'hFFFF2, 2, 5, FMT_ULAW);
    chk(n, 5);
    chk(pb_busy, 1);
    wr(OFS_PB_LOOP, 32'h0);
    for (n = 0; n < 2000 && pb_busy !== 1'b0; n++)
      @(posedge clk);
    chk(pb_busy, 0);
    if (pb_busy !== 1'b0)
      conclude;
    t_play(20'h00200, 2, FMT_ADPCM);
    watch(20'h00200, 2, 4, FMT_ADPCM);
    chk(n, 4);
    conclude;
  end

endmodule // audio_playback_control_regs_tb
